// ### dv/htp_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// link side model
module htp_link_model (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic stall_i,
  input  wire logic tx_link_valid_i,
  output logic      tx_link_ready_o,
  output logic      char_done_o,
  output logic      got_o
);
  logic [1:0] ph_r;
  always_ff @(posedge sys_clk_i) begin
    ph_r  <= reset_n_i ? ph_r + 2'h1 : 2'h0;
    got_o <= reset_n_i && tx_link_ready_o && tx_link_valid_i;
  end
  // slow drain and sparse char ends, so queue and send wait are both stressed
  assign tx_link_ready_o = !stall_i && ph_r[0];
  assign char_done_o     = (ph_r == 2'h3);
endmodule // htp_link_model
`default_nettype wire

// ### dv/htp_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks
module htp_port_checker (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       link_run_i,
  input wire logic       char_done_i,
  input wire logic       rx_tc_strobe_i,
  input wire logic [7:0] rx_tc_val_i,
  input wire logic [7:0] time_val_o,
  input wire logic       tick_arrive_o,
  input wire logic       tc_send_o,
  input wire logic       port_select_n_i,
  input wire logic       rx_pop_n_i,
  input wire logic       rx_oe_n_i,
  input wire logic [8:0] rx_data_o,
  input wire logic       rx_data_oe_n_o,
  input wire logic       send_queue_full_o,
  input wire logic       send_queue_near_full_o,
  input wire logic       recv_queue_empty_o,
  input wire logic       recv_queue_near_empty_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire take_tc = rx_tc_strobe_i && link_run_i;
  wire good_tc = take_tc && (rx_tc_val_i == time_val_o + 8'h01);
  a_tick_on_good: assert property (good_tc |=> tick_arrive_o)
    else $error("tick missing");
  a_tick_cause: assert property (tick_arrive_o |-> $past(good_tc))
    else $error("tick without valid code");
  a_no_run_tick: assert property (!link_run_i |=> !tick_arrive_o)
    else $error("tick outside run");
  a_value_load: assert property (take_tc |=> time_val_o == $past(rx_tc_val_i))
    else $error("time value wrong");
  a_send_edge: assert property (tc_send_o |-> $past(link_run_i && char_done_i))
    else $error("send not at char end");
  a_full_near: assert property (send_queue_full_o |-> send_queue_near_full_o)
    else $error("full without near full");
  a_empty_near: assert property (recv_queue_empty_o |-> recv_queue_near_empty_o)
    else $error("empty without near empty");
  a_oe_follow: assert property (##1 rx_data_oe_n_o == $past(rx_oe_n_i | port_select_n_i))
    else $error("output enable wrong");
  a_pop_empty: assert property (!rx_pop_n_i && !port_select_n_i && recv_queue_empty_o
    |=> $stable(rx_data_o)) else $error("empty pop moved data");
endmodule // htp_port_checker
bind htp_port htp_port_checker htp_port_checker_inst (.*);
`default_nettype wire

// ### dv/htp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module htp_port_test;
  logic sys_clk_i, reset_n_i, tick_req_i, link_run_i, char_done_i, rx_tc_strobe_i;
  logic port_select_n_i, tx_push_n_i, rx_pop_n_i, rx_oe_n_i, tx_link_ready_i, rx_link_valid_i;
  logic tick_arrive_o, tc_send_o, send_queue_full_o, send_queue_near_full_o, rx_data_oe_n_o;
  logic recv_queue_empty_o, recv_queue_near_empty_o, tx_link_valid_o, rx_link_ready_o;
  logic [7:0] time_val_i, rx_tc_val_i, time_val_o, tc_send_val_o, tm;
  logic [8:0] tx_data_i, rx_data_o, tx_link_data_o, rx_link_data_i;
  logic [8:0] q_tx[$], q_rx[$], q_tc[$], q_tk[$];
  logic [31:0] rs = 32'h00013F1E;
  logic stall, got, pop_seen;
  int fail_count = 0;
  int cmp_count = 0;
  htp_port #(.Q_DEPTH(16), .MARGIN(8)) htp_port_inst (.*);
  htp_link_model htp_link_model_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .stall_i(stall), .tx_link_valid_i(tx_link_valid_o), .tx_link_ready_o(tx_link_ready_i),
    .char_done_o(char_done_i), .got_o(got));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic chkb(input logic s, input logic e);
    chk({8'h00, s}, {8'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // monitor: oldest note against each result as it shows
  always @(posedge sys_clk_i) pop_seen <= !rx_pop_n_i && !port_select_n_i && !recv_queue_empty_o;
  always @(negedge sys_clk_i) begin
    if (pop_seen) chk(rx_data_o, q_rx.pop_front());
    if (got) chk(tx_link_data_o, q_tx.pop_front());
    if (tc_send_o) chk({1'b0, tc_send_val_o}, q_tc.pop_front());
    if (tick_arrive_o) chk({1'b0, time_val_o}, q_tk.pop_front());
  end
  initial begin
    cyc(2000);
    fail_count++;
    give_verdict();
  end
  initial begin
    {tick_req_i, link_run_i, rx_tc_strobe_i, rx_link_valid_i, stall, tm} = '0;
    {port_select_n_i, tx_push_n_i, rx_pop_n_i, rx_oe_n_i} = 4'hF;
    {time_val_i, rx_tc_val_i, tx_data_i, rx_link_data_i} = '0;
    reset_n_i = 1'b0;
    cyc(5);
    reset_n_i = 1'b1;
    cyc(1);
    chk({recv_queue_empty_o, recv_queue_near_empty_o, send_queue_full_o, rx_data_oe_n_o}, 9'h00D);
    $display("reset test done");
    stall = 1'b1;
    tx_push_n_i = 1'b0;
    cyc(1);
    chkb(tx_link_valid_o, 1'b0);
    port_select_n_i = 1'b0;
    for (int i = 1; i <= 17; i++) begin
      tx_data_i = 9'(rnd());
      if (i <= 16) q_tx.push_back(tx_data_i);
      cyc(1);
      chkb(send_queue_near_full_o, i >= 8);
      chkb(send_queue_full_o, i >= 16);
    end
    tx_push_n_i = 1'b1;
    stall = 1'b0;
    for (int k = 0; k < 200 && tx_link_valid_o; k++) cyc(1);
    $display("send queue test done");
    rx_link_valid_i = 1'b1;
    for (int i = 1; i <= 17; i++) begin
      rx_link_data_i = 9'(rnd());
      if (i <= 16) q_rx.push_back(rx_link_data_i);
      cyc(1);
    end
    chkb(rx_link_ready_o, 1'b0);
    rx_link_valid_i = 1'b0;
    rx_oe_n_i = 1'b0;
    rx_pop_n_i = 1'b0;
    for (int c = 16; c >= 0; c--) begin
      cyc(1);
      chkb(recv_queue_near_empty_o, c <= 9);
      chkb(recv_queue_empty_o, c <= 1);
      chkb(rx_data_oe_n_o, 1'b0);
    end
    {rx_pop_n_i, rx_oe_n_i} = 2'h3;
    cyc(1);
    chkb(rx_data_oe_n_o, 1'b1);
    $display("receive queue test done");
    for (int i = 0; i < 24; i++) begin
      rx_tc_val_i = (i % 3 == 2) ? 8'(rnd()) : tm + 8'h01;
      rx_tc_strobe_i = 1'b1;
      link_run_i = (i % 5 != 4);
      if (link_run_i && rx_tc_val_i == tm + 8'h01) q_tk.push_back({1'b0, rx_tc_val_i});
      if (link_run_i) tm = rx_tc_val_i;
      cyc(1);
    end
    rx_tc_strobe_i = 1'b0;
    $display("time receive test done");
    for (int i = 0; i < 4; i++) begin
      time_val_i = 8'(rnd());
      tick_req_i = 1'b1;
      link_run_i = (i != 2);
      if (link_run_i) q_tc.push_back({1'b0, time_val_i});
      cyc(1);
      tick_req_i = 1'b0;
      cyc(8);
    end
    $display("time send test done");
    chk(9'(q_tx.size() + q_rx.size() + q_tc.size() + q_tk.size()), 9'h000);
    give_verdict();
  end
endmodule // htp_port_test
`default_nettype wire

// ### hw/htp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module htp_fifo #(
  parameter int unsigned W      = 9,
  parameter int unsigned DEPTH  = 128,
  parameter int unsigned MARGIN = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         wr_valid_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic              wr_ready_o,
  input  wire logic         rd_ready_i,
  output logic              rd_valid_o,
  output logic [W-1:0]      rd_data_o,
  output logic              full_o,
  output logic              empty_o,
  output logic              near_full_o,
  output logic              near_empty_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_MRG = CW'(MARGIN);
  localparam logic [AW-1:0] PTR_TOP = AW'(DEPTH - 1);
  localparam logic          NF_RST  = (DEPTH <= MARGIN);

  // ==========================================================
  // pointer arithmetic
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == PTR_TOP) ? '0 : p + AW'(1);
  endfunction

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic [W-1:0]  rd_data_r;
  logic          full_r;
  logic          empty_r;
  logic          near_full_r;
  logic          near_empty_r;

  // overflow and underflow attempts are dropped here
  wire logic          do_wr   = wr_valid_i & ~full_r;   // [R16]
  wire logic          do_rd   = rd_ready_i & ~empty_r;  // [R16]
  wire logic [CW-1:0] cnt_nxt = cnt_r + CW'(do_wr) - CW'(do_rd);
  wire logic [CW-1:0] free_nxt = CNT_MAX - cnt_nxt;

  // ==========================================================
  // storage, no reset so it maps to ram
  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= wr_data_i;
    end
  end

  // ==========================================================
  // pointers, count, flags from the next count
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_r     <= '0;
      rd_ptr_r     <= '0;
      cnt_r        <= '0;
      rd_data_r    <= '0;
      full_r       <= 1'b0;
      empty_r      <= 1'b1;
      near_full_r  <= NF_RST;
      near_empty_r <= 1'b1;
    end else begin
      if (do_wr) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (do_rd) rd_ptr_r <= ptr_inc(rd_ptr_r);
      if (do_rd) rd_data_r <= mem[rd_ptr_r];      // [R10]
      cnt_r        <= cnt_nxt;
      // flags settle on the same edge as the causing transfer
      full_r       <= (cnt_nxt == CNT_MAX);       // [R13] [R14]
      empty_r      <= (cnt_nxt == '0);            // [R13] [R14]
      near_full_r  <= (free_nxt <= CNT_MRG);      // [R11]
      near_empty_r <= (cnt_nxt <= CNT_MRG);       // [R12]
    end
  end

  assign wr_ready_o   = ~full_r;
  assign rd_valid_o   = ~empty_r;
  assign rd_data_o    = rd_data_r;
  assign full_o       = full_r;
  assign empty_o      = empty_r;
  assign near_full_o  = near_full_r;
  assign near_empty_o = near_empty_r;

endmodule // htp_fifo

`default_nettype wire

// ### hw/htp_pkg.sv
package htp_pkg;

  // ==========================================================
  // widths and depths
  localparam int unsigned TC_W        = 8;
  localparam int unsigned Q_W         = 9;
  localparam int unsigned Q_DEPTH     = 128;
  localparam int unsigned NEAR_MARGIN = 8;

  // ==========================================================
  // reset values and time counter step
  localparam logic [TC_W-1:0] TC_RESET  = 8'h00;
  localparam logic [TC_W-1:0] TC_STEP   = 8'h01;
  localparam logic [Q_W-1:0]  QD_RESET  = 9'h000;

  // ==========================================================
  // time-code send sequencer
  typedef enum logic [0:0] {
    HTP_TC_IDLE,
    HTP_TC_PEND
  } htp_tc_state_t;

endpackage

// ### hw/htp_port.sv
// Overview of operation
// [R1] time request sends time-code from value bus
// [R2] send only in Run, after current character
// [R3] arrival strobe on valid code in Run
// [R4] value bus shows current time counter
// [R5] valid code equals counter plus one
// [R6] host holds request and value over edge
// [R7] arrival strobe driven from clock edges
// [R8] value bus updates only after clock edges
// [R9] push on edge with strobe and select low
// [R10] pop on edge, data changes after it
// [R11] near-full while eight or fewer slots free
// [R12] near-empty while eight or fewer words left
// [R13] send flags update with the causing push
// [R14] receive flags update with the causing pop
// [R15] receive data driven only when enabled; rx_data_oe_n_o follows rx_oe_n_i and port_select_n_i one clock late
// [R16] full push or empty pop changes nothing
// [R17] host throttles using full and near flags
`timescale 1ns/1ps
`default_nettype none

module htp_port #(
  parameter int unsigned Q_DEPTH = htp_pkg::Q_DEPTH,
  parameter int unsigned MARGIN  = htp_pkg::NEAR_MARGIN
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_n_i,
  // host time-code side
  input  wire logic                       tick_req_i,
  input  wire logic [htp_pkg::TC_W-1:0]   time_val_i,
  output logic      [htp_pkg::TC_W-1:0]   time_val_o,
  output logic                            tick_arrive_o,
  // link side time-code
  input  wire logic                       link_run_i,
  input  wire logic                       char_done_i,
  output logic                            tc_send_o,
  output logic      [htp_pkg::TC_W-1:0]   tc_send_val_o,
  input  wire logic                       rx_tc_strobe_i,
  input  wire logic [htp_pkg::TC_W-1:0]   rx_tc_val_i,
  // host queue side
  input  wire logic                       port_select_n_i,
  input  wire logic                       tx_push_n_i,
  input  wire logic [htp_pkg::Q_W-1:0]    tx_data_i,
  output logic                            send_queue_full_o,
  output logic                            send_queue_near_full_o,
  input  wire logic                       rx_pop_n_i,
  input  wire logic                       rx_oe_n_i,
  output logic      [htp_pkg::Q_W-1:0]    rx_data_o,
  output logic                            rx_data_oe_n_o,
  output logic                            recv_queue_empty_o,
  output logic                            recv_queue_near_empty_o,
  // link side queues
  input  wire logic                       tx_link_ready_i,
  output logic                            tx_link_valid_o,
  output logic      [htp_pkg::Q_W-1:0]    tx_link_data_o,
  input  wire logic                       rx_link_valid_i,
  input  wire logic [htp_pkg::Q_W-1:0]    rx_link_data_i,
  output logic                            rx_link_ready_o
);

  // ==========================================================
  // time-code state
  htp_pkg::htp_tc_state_t         tc_state_r;
  htp_pkg::htp_tc_state_t         tc_state_nxt;
  logic [htp_pkg::TC_W-1:0]       time_cnt_r;
  logic [htp_pkg::TC_W-1:0]       time_cnt_nxt;
  logic [htp_pkg::TC_W-1:0]       send_val_r;
  logic [htp_pkg::TC_W-1:0]       time_val_r;
  logic                           tick_arrive_r;
  logic                           tc_send_r;
  logic [htp_pkg::TC_W-1:0]       tc_send_val_r;
  logic                           rx_oe_n_r;

  // ==========================================================
  // decode
  // request and value are sampled together on one edge
  wire logic take_req  = tick_req_i & link_run_i & (tc_state_r == htp_pkg::HTP_TC_IDLE); // [R1] [R6]
  wire logic rx_tc     = rx_tc_strobe_i & link_run_i;
  wire logic rx_valid  = rx_tc & (rx_tc_val_i == time_cnt_r + htp_pkg::TC_STEP);        // [R5]
  wire logic send_now  = (tc_state_r == htp_pkg::HTP_TC_PEND) & link_run_i & char_done_i; // [R2]
  wire logic push_req  = ~tx_push_n_i & ~port_select_n_i;   // [R9]
  wire logic pop_req   = ~rx_pop_n_i & ~port_select_n_i;    // [R10]

  // ==========================================================
  // send sequencer
  always_comb begin
    tc_state_nxt = tc_state_r;
    unique case (tc_state_r)
      htp_pkg::HTP_TC_IDLE: begin
        if (take_req) tc_state_nxt = htp_pkg::HTP_TC_PEND;
      end
      htp_pkg::HTP_TC_PEND: begin
        // a dropped link cancels the pending code
        if (!link_run_i || char_done_i) tc_state_nxt = htp_pkg::HTP_TC_IDLE; // [R2]
      end
    endcase
  end

  // received code wins the counter if both land together
  assign time_cnt_nxt = rx_tc    ? rx_tc_val_i :
                        take_req ? time_val_i  : time_cnt_r;

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tc_state_r    <= htp_pkg::HTP_TC_IDLE;
      time_cnt_r    <= htp_pkg::TC_RESET;
      send_val_r    <= htp_pkg::TC_RESET;
      time_val_r    <= htp_pkg::TC_RESET;
      tick_arrive_r <= 1'b0;
      tc_send_r     <= 1'b0;
      tc_send_val_r <= htp_pkg::TC_RESET;
      rx_oe_n_r     <= 1'b1;
    end else begin
      tc_state_r    <= tc_state_nxt;
      time_cnt_r    <= time_cnt_nxt;
      if (take_req) send_val_r <= time_val_i;    // [R1]
      time_val_r    <= time_cnt_nxt;             // [R4] [R8]
      tick_arrive_r <= rx_valid;                 // [R3] [R7]
      tc_send_r     <= send_now;                 // [R2]
      if (send_now) tc_send_val_r <= send_val_r;
      // one cycle late on both enable and release; host must allow a clock
      rx_oe_n_r     <= rx_oe_n_i | port_select_n_i; // [R15]
    end
  end

  assign time_val_o     = time_val_r;
  assign tick_arrive_o  = tick_arrive_r;
  assign tc_send_o      = tc_send_r;
  assign tc_send_val_o  = tc_send_val_r;
  assign rx_data_oe_n_o = rx_oe_n_r;

  // ==========================================================
  // send queue: host pushes, link drains
  htp_fifo #(
    .W      (htp_pkg::Q_W),
    .DEPTH  (Q_DEPTH),
    .MARGIN (MARGIN)
  ) u_send_q (
    .sys_clk_i    (sys_clk_i),
    .reset_n_i    (reset_n_i),
    .wr_valid_i   (push_req),                    // [R9] [R17]
    .wr_data_i    (tx_data_i),
    .wr_ready_o   (),
    .rd_ready_i   (tx_link_ready_i),
    .rd_valid_o   (tx_link_valid_o),
    .rd_data_o    (tx_link_data_o),
    .full_o       (send_queue_full_o),           // [R13]
    .empty_o      (),
    .near_full_o  (send_queue_near_full_o),      // [R11]
    .near_empty_o ()
  );

  // ==========================================================
  // receive queue: link fills, host pops
  htp_fifo #(
    .W      (htp_pkg::Q_W),
    .DEPTH  (Q_DEPTH),
    .MARGIN (MARGIN)
  ) u_recv_q (
    .sys_clk_i    (sys_clk_i),
    .reset_n_i    (reset_n_i),
    .wr_valid_i   (rx_link_valid_i),
    .wr_data_i    (rx_link_data_i),
    .wr_ready_o   (rx_link_ready_o),
    .rd_ready_i   (pop_req),                     // [R10] [R17]
    .rd_valid_o   (),
    .rd_data_o    (rx_data_o),                   // [R10]
    .full_o       (),
    .empty_o      (recv_queue_empty_o),          // [R14]
    .near_full_o  (),
    .near_empty_o (recv_queue_near_empty_o)      // [R12]
  );

endmodule // htp_port

`default_nettype wire
